// ===== pkg/imab_pkg.sv
// Constants shared by the assembly window and its pointer bank
package imab_pkg;

  // ************************************************************
  // Register map (Modbus register numbers)
  // ************************************************************
  localparam logic [15:0] DEF_BASE_ADDR = 16'h0028;   // First definition register
  localparam logic [15:0] WORK_BASE_ADDR = 16'h00C8;  // First working register
  localparam logic [15:0] ADDR_POINTER_FIRST_LO = 16'h0028;
  localparam logic [15:0] ADDR_POINTER_FIRST_HI = 16'h0029;
  localparam logic [15:0] ADDR_POINTER_EXAMPLE_LO = 16'h005A;
  localparam logic [15:0] ADDR_POINTER_EXAMPLE_HI = 16'h005B;
  localparam logic [15:0] ADDR_WINDOW_FIRST_LO = 16'h00C8;
  localparam logic [15:0] ADDR_WINDOW_FIRST_HI = 16'h00C9;
  localparam logic [15:0] ADDR_WINDOW_DEFAULT_LO = 16'h00F0;
  localparam logic [15:0] ADDR_WINDOW_DEFAULT_HI = 16'h00F1;
  localparam logic [15:0] ADDR_WINDOW_EXAMPLE_LO = 16'h00FA;
  localparam logic [15:0] ADDR_WINDOW_EXAMPLE_HI = 16'h00FB;

  // ************************************************************
  // Sizes and reset values
  // ************************************************************
  localparam int NUM_PARAMS = 40;                      // Parameters in the window
  localparam int DEFAULT_SLOT_IDX = 40;                // Pointer register index of the default map
  localparam logic [15:0] PTR_RESET_VAL = 16'h0000;    // Unprogrammed pointer
  localparam logic [15:0] PTR_DEFAULT_LO = 16'h0168;   // Analog input value, low word
  localparam logic [15:0] PTR_DEFAULT_HI = 16'h0169;   // Analog input value, high word

  // ************************************************************
  // Modbus function and exception codes
  // ************************************************************
  localparam logic [7:0] FUNC_READ_HOLD = 8'h03;
  localparam logic [7:0] FUNC_READ_INPUT = 8'h04;
  localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam logic [7:0] PAR_TIMEOUT_CYC = 8'hFF;      // Cycles to wait for the parameter store

endpackage : imab_pkg

// ===== hdl/imab_ptr_bank.sv
// Pointer store for the definition registers
`timescale 1ns/1ps

module imab_ptr_bank
  import imab_pkg::*;
#(
  parameter int N_REGS = 2 * NUM_PARAMS,
  parameter int IDX_W = $clog2(2 * NUM_PARAMS)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [15:0] rd_data
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] ptr_reg [N_REGS];
  logic [15:0] ptr_next [N_REGS];

  initial begin
    if (N_REGS > (1 << IDX_W) || DEFAULT_SLOT_IDX + 1 >= N_REGS) begin
      $error("imab_ptr_bank: index width too small for the bank");
    end
  end

  // Per-entry next value and reset default
  generate
    for (genvar i = 0; i < N_REGS; i++) begin : g_ptr
      localparam logic [15:0] RST_VAL = (i == DEFAULT_SLOT_IDX) ? PTR_DEFAULT_LO :
                                        (i == DEFAULT_SLOT_IDX + 1) ? PTR_DEFAULT_HI : PTR_RESET_VAL;
      always_comb begin
        ptr_next[i] = ptr_reg[i];
        if (wr_en && (32'(wr_idx) == i)) begin
          ptr_next[i] = wr_data;
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ptr_reg[i] <= RST_VAL;
        end else begin
          ptr_reg[i] <= ptr_next[i];
        end
      end
    end
  endgenerate

  // Out-of-range index reads as the unprogrammed value
  assign rd_data = (32'(rd_idx) < N_REGS) ? ptr_reg[rd_idx] : PTR_RESET_VAL;

  // Default map is present right after reset
  a_default_map: assert property (@(posedge clk) $past(!rst_n) && rst_n |->
    ptr_reg[DEFAULT_SLOT_IDX] == PTR_DEFAULT_LO && ptr_reg[DEFAULT_SLOT_IDX + 1] == PTR_DEFAULT_HI)
    else $error("default analog input map missing after reset");

  // A write lands in the addressed entry
  a_ptr_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && 32'(wr_idx) < N_REGS |=> ptr_reg[$past(wr_idx)] == $past(wr_data))
    else $error("pointer write not stored");

endmodule : imab_ptr_bank

// ===== hdl/imab_core.sv
// Indirect Modbus assembly window: definition pointers and forwarded working registers
`timescale 1ns/1ps

module imab_core
  import imab_pkg::*;
#(
  parameter int N_PARAMS = NUM_PARAMS
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Register request from the Modbus frame engine, one register each
  input wire logic REQ_VALID,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  output logic REQ_READY,
  // Register answer
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA,
  output logic RSP_EXCEPTION,
  output logic [7:0] RSP_EXC_CODE,
  // Parameter store access
  output logic PAR_REQ,
  output logic PAR_WE,
  output logic [15:0] PAR_ADDR,
  output logic [15:0] PAR_WDATA,
  input wire logic PAR_ACK,
  input wire logic [15:0] PAR_RDATA,
  input wire logic PAR_WRITABLE
);

  // ************************************************************
  // Sizing
  // ************************************************************
  localparam int N_REGS = 2 * N_PARAMS;
  localparam int IDX_W = $clog2(2 * NUM_PARAMS);

  // Window must fit the index and hold the default map slot at index 40 and 41
  initial begin
    if (N_PARAMS < 21 || N_PARAMS > NUM_PARAMS) begin
      $error("imab_core: N_PARAMS must lie between 21 and the documented 40");
    end
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PAR_RD,
    ST_PAR_WR,
    ST_RSP
  } imab_state_e;

  // ************************************************************
  // State
  // ************************************************************
  imab_state_e state_reg, state_next;
  logic is_write_reg, is_write_next;
  logic [15:0] par_addr_reg, par_addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdata_reg, rdata_next;
  logic exc_reg, exc_next;
  logic [7:0] exc_code_reg, exc_code_next;
  logic [7:0] tmo_reg, tmo_next;

  // Decode of the incoming address
  logic in_def;
  logic in_work;
  logic [IDX_W-1:0] req_idx;
  logic [15:0] cur_ptr;
  logic bank_we;
  logic accept;

  assign accept = REQ_VALID && REQ_READY;
  assign in_def = (REQ_ADDR >= DEF_BASE_ADDR) && (REQ_ADDR < DEF_BASE_ADDR + 16'(N_REGS));
  assign in_work = (REQ_ADDR >= WORK_BASE_ADDR) && (REQ_ADDR < WORK_BASE_ADDR + 16'(N_REGS));

  // Same offset into either block selects the same pointer
  always_comb begin
    req_idx = '0;
    if (in_def) begin
      req_idx = IDX_W'(REQ_ADDR - DEF_BASE_ADDR);
    end else if (in_work) begin
      req_idx = IDX_W'(REQ_ADDR - WORK_BASE_ADDR);
    end
  end

  // Pointer writes go only through function 16
  assign bank_we = accept && in_def && (REQ_FUNC == FUNC_WRITE_MULTI);

  imab_ptr_bank #(
    .N_REGS(N_REGS),
    .IDX_W(IDX_W)
  ) u_ptr_bank (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .wr_en(bank_we),
    .wr_idx(req_idx),
    .wr_data(REQ_WDATA),
    .rd_idx(req_idx),
    .rd_data(cur_ptr)
  );

  // ************************************************************
  // Request sequencer
  // ************************************************************
  // Writes to a working register first probe the target, so a read-only
  // parameter never sees a write strobe at all; costs one extra round trip.
  always_comb begin
    state_next = state_reg;
    is_write_next = is_write_reg;
    par_addr_next = par_addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    exc_next = exc_reg;
    exc_code_next = exc_code_reg;
    tmo_next = tmo_reg;
    case (state_reg)
      ST_IDLE: begin
        if (REQ_VALID) begin
          exc_next = 1'b0;
          exc_code_next = 8'h00;
          rdata_next = 16'h0000;
          is_write_next = (REQ_FUNC == FUNC_WRITE_MULTI);
          wdata_next = REQ_WDATA;
          tmo_next = 8'h00;
          state_next = ST_RSP;
          if (!(in_def || in_work)) begin
            exc_next = 1'b1;
            exc_code_next = EXC_ILLEGAL_ADDR;
          end else if (REQ_FUNC == FUNC_WRITE_SINGLE) begin
            exc_next = 1'b1;
            exc_code_next = EXC_ILLEGAL_FUNC;
          end else if (REQ_FUNC != FUNC_WRITE_MULTI && REQ_FUNC != FUNC_READ_HOLD &&
                       REQ_FUNC != FUNC_READ_INPUT) begin
            exc_next = 1'b1;
            exc_code_next = EXC_ILLEGAL_FUNC;
          end else if (in_def) begin
            rdata_next = cur_ptr;
          end else begin
            par_addr_next = cur_ptr;
            state_next = ST_PAR_RD;
          end
        end
      end
      ST_PAR_RD: begin
        tmo_next = tmo_reg + 8'h01;
        if (PAR_ACK) begin
          rdata_next = PAR_RDATA;
          tmo_next = 8'h00;
          if (!is_write_reg) begin
            state_next = ST_RSP;
          end else if (PAR_WRITABLE) begin
            state_next = ST_PAR_WR;
          end else begin
            state_next = ST_RSP;
          end
        end else if (tmo_reg == PAR_TIMEOUT_CYC) begin
          exc_next = 1'b1;
          exc_code_next = EXC_DEVICE_FAIL;
          state_next = ST_RSP;
        end
      end
      ST_PAR_WR: begin
        tmo_next = tmo_reg + 8'h01;
        if (PAR_ACK) begin
          rdata_next = wdata_reg;
          state_next = ST_RSP;
        end else if (tmo_reg == PAR_TIMEOUT_CYC) begin
          exc_next = 1'b1;
          exc_code_next = EXC_DEVICE_FAIL;
          state_next = ST_RSP;
        end
      end
      ST_RSP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      is_write_reg <= 1'b0;
      par_addr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      exc_reg <= 1'b0;
      exc_code_reg <= 8'h00;
      tmo_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      is_write_reg <= is_write_next;
      par_addr_reg <= par_addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      exc_reg <= exc_next;
      exc_code_reg <= exc_code_next;
      tmo_reg <= tmo_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Handshakes are decoded from state, data comes from flops
  assign REQ_READY = (state_reg == ST_IDLE);
  assign RSP_VALID = (state_reg == ST_RSP);
  assign RSP_RDATA = rdata_reg;
  assign RSP_EXCEPTION = exc_reg;
  assign RSP_EXC_CODE = exc_code_reg;
  assign PAR_REQ = (state_reg == ST_PAR_RD) || (state_reg == ST_PAR_WR);
  assign PAR_WE = (state_reg == ST_PAR_WR);
  assign PAR_ADDR = par_addr_reg;
  assign PAR_WDATA = wdata_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  a_single_write_refused: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    accept && (in_def || in_work) && REQ_FUNC == FUNC_WRITE_SINGLE |=>
    RSP_VALID && RSP_EXCEPTION && RSP_EXC_CODE == EXC_ILLEGAL_FUNC && !PAR_REQ)
    else $error("function 06 on assembly not refused");

  a_single_no_store: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    accept && REQ_FUNC == FUNC_WRITE_SINGLE |-> !bank_we ##1 !PAR_WE [*2])
    else $error("function 06 changed state");

  a_unmapped_addr: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    accept && !in_def && !in_work |=> RSP_EXCEPTION && RSP_EXC_CODE == EXC_ILLEGAL_ADDR)
    else $error("address outside the assembly not rejected");

  a_work_points_target: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    accept && in_work && (REQ_FUNC == FUNC_READ_HOLD || REQ_FUNC == FUNC_WRITE_MULTI) |=>
    PAR_REQ && !PAR_WE && PAR_ADDR == $past(cur_ptr))
    else $error("working register not routed to its pointer");

  a_read_returns_value: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_reg == ST_PAR_RD && PAR_ACK && !is_write_reg |=>
    RSP_VALID && !RSP_EXCEPTION && RSP_RDATA == $past(PAR_RDATA))
    else $error("working read did not return the parameter value");

  a_write_forwarded: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_reg == ST_PAR_RD && PAR_ACK && is_write_reg && PAR_WRITABLE |=>
    PAR_REQ && PAR_WE && PAR_WDATA == wdata_reg && PAR_ADDR == $past(PAR_ADDR))
    else $error("write to writable target not forwarded");

  a_readonly_kept: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    state_reg == ST_PAR_RD && PAR_ACK && is_write_reg && !PAR_WRITABLE |=> !PAR_WE ##1 !PAR_WE)
    else $error("read-only target received a write");

  a_def_write_ok: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    bank_we |=> RSP_VALID && !RSP_EXCEPTION ##1 !RSP_VALID)
    else $error("pointer write not acknowledged");

  // A forwarded write holds the request through both phases, each of which may run to its own timeout
  a_par_bounded: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    $rose(PAR_REQ) |-> ##[1:513] RSP_VALID)
    else $error("parameter access never answered");

endmodule : imab_core

// ===== bench/imab_par_store.sv
// Parameter store model behind the assembly window
`timescale 1ns/1ps

module imab_par_store (
  // Clock and answer delay
  input wire logic clk,
  input wire logic [9:0] dly,
  // Store request
  input wire logic par_req,
  input wire logic par_we,
  input wire logic [15:0] par_addr,
  input wire logic [15:0] par_wdata,
  // Store answer
  output logic par_ack,
  output logic [15:0] par_rdata,
  output logic par_writable
);
  logic [15:0] mem [0:1023];
  logic ro;
  logic done;
  logic we_seen;
  int cnt;

  // Block 1xx is read-only, like the analog input value
  assign ro = (par_addr[9:8] == 2'b01);

  // Known contents so the bench can predict every read
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'(i) ^ 16'h5A5A;
    end
    par_ack = 1'b0;
    par_rdata = 16'h0000;
    par_writable = 1'b0;
    done = 1'b0;
    we_seen = 1'b0;
    cnt = 0;
  end

  // One answer per phase; stale data toggles so a late sample cannot pass
  always @(posedge clk) begin
    par_ack <= 1'b0;
    par_rdata <= ~par_rdata;
    par_writable <= ~par_writable;
    if (!par_req || par_we != we_seen) begin
      cnt <= 0;
      done <= 1'b0;
      we_seen <= par_we;
    end else if (!done && cnt >= int'(dly)) begin
      par_ack <= 1'b1;
      done <= 1'b1;
      par_rdata <= mem[par_addr[9:0]];
      par_writable <= !ro;
      if (par_we && !ro) begin
        mem[par_addr[9:0]] <= par_wdata;
      end
    end else if (!done) begin
      cnt <= cnt + 1;
    end
  end
endmodule : imab_par_store

// ===== bench/indirect_modbus_assembly_block_tb.sv
// Self-checking bench for the indirect Modbus assembly window
`timescale 1ns/1ps

module indirect_modbus_assembly_block_tb
  import imab_pkg::*;
;
  typedef struct packed {
    logic exc;
    logic [7:0] code;
    logic [15:0] data;
    logic chk;
  } imab_exp_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [9:0] dly = 10'h000;
  logic req_ready, rsp_valid, rsp_exception, par_req, par_we, par_ack, par_writable;
  logic [15:0] rsp_rdata, par_addr, par_wdata, par_rdata, w;
  logic [7:0] rsp_exc_code;
  logic [15:0] shadow [0:1023];
  logic [15:0] ptr [0:79];
  logic [15:0] bad [0:3] = '{16'h0027, 16'h0078, 16'h00C7, 16'h0118};
  imab_exp_s expq [$];
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] lfsr = 32'h5333FAAC;

  always #2.5 ref_clk = ~ref_clk;

  imab_core #(.N_PARAMS(40)) DUT (.REF_CLK(ref_clk), .RSTN(rstn), .REQ_VALID(req_valid),
    .REQ_FUNC(req_func), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_EXCEPTION(rsp_exception),
    .RSP_EXC_CODE(rsp_exc_code), .PAR_REQ(par_req), .PAR_WE(par_we), .PAR_ADDR(par_addr),
    .PAR_WDATA(par_wdata), .PAR_ACK(par_ack), .PAR_RDATA(par_rdata), .PAR_WRITABLE(par_writable));

  imab_par_store u_store (.clk(ref_clk), .dly(dly), .par_req(par_req), .par_we(par_we),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_ack(par_ack), .par_rdata(par_rdata),
    .par_writable(par_writable));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic imab_exp_s e_ok(input logic [15:0] d);
    return {1'b0, 8'h00, d, 1'b1};
  endfunction : e_ok

  function automatic imab_exp_s e_exc(input logic [7:0] c);
    return {1'b1, c, 16'h0000, 1'b1};
  endfunction : e_exc

  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic check_resp(input imab_exp_s e);
    n_checks++;
    if (rsp_exception !== e.exc || (e.exc && rsp_exc_code !== e.code) || (e.chk && rsp_rdata !== e.data)) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h_%h_%h exp=%h_%h_%h", $time, rsp_exception, rsp_exc_code, rsp_rdata,
        e.exc, e.code, e.data);
    end
  endtask : check_resp

  // Present one register request at a falling edge, hold it across the taking edge
  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input imab_exp_s e);
    @(negedge ref_clk);
    for (int k = 0; req_ready !== 1'b1; k++) begin
      if (k > 600) begin
        n_errors++;
        end_of_test();
      end
      @(negedge ref_clk);
    end
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_wdata = d;
    expq.push_back(e);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask : req

  // Wait until every noted answer has come back
  task automatic drain;
    for (int k = 0; expq.size() > 0; k++) begin
      if (k > 600) begin
        n_errors++;
        end_of_test();
      end
      @(negedge ref_clk);
    end
  endtask : drain

  // Answers are settled by the falling edge of their one-cycle pulse
  always @(negedge ref_clk) begin
    if (rstn === 1'b1 && rsp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=none", $time, rsp_rdata);
      end else begin
        check_resp(expq.pop_front());
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    for (int i = 0; i < 1024; i++) begin
      shadow[i] = 16'(i) ^ 16'h5A5A;
    end
    // Pointer model after reset: all unprogrammed except the default analog input map
    for (int i = 0; i < 80; i++) begin
      ptr[i] = PTR_RESET_VAL;
    end
    ptr[DEFAULT_SLOT_IDX] = PTR_DEFAULT_LO;
    ptr[DEFAULT_SLOT_IDX + 1] = PTR_DEFAULT_HI;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    req(FUNC_READ_HOLD, 16'h0050, 16'h0000, e_ok(PTR_DEFAULT_LO));
    req(FUNC_READ_HOLD, ADDR_WINDOW_DEFAULT_LO, 16'h0000, e_ok(shadow[10'h168]));
    req(FUNC_READ_INPUT, ADDR_WINDOW_DEFAULT_HI, 16'h0000, e_ok(shadow[10'h169]));
    req(FUNC_WRITE_MULTI, ADDR_POINTER_EXAMPLE_LO, 16'h0168, e_ok(16'h0000));
    req(FUNC_WRITE_MULTI, ADDR_POINTER_EXAMPLE_HI, 16'h0169, e_ok(16'h0000));
    ptr[50] = 16'h0168;
    ptr[51] = 16'h0169;
    req(FUNC_READ_HOLD, ADDR_WINDOW_EXAMPLE_LO, 16'h0000, e_ok(shadow[10'h168]));
    req(FUNC_READ_HOLD, ADDR_WINDOW_EXAMPLE_HI, 16'h0000, e_ok(shadow[10'h169]));
    req(FUNC_WRITE_SINGLE, ADDR_POINTER_EXAMPLE_LO, 16'h0200, e_exc(EXC_ILLEGAL_FUNC));
    req(FUNC_READ_HOLD, ADDR_POINTER_EXAMPLE_LO, 16'h0000, e_ok(16'h0168));
    // Read-only target answers normally but keeps its value
    req(FUNC_WRITE_MULTI, ADDR_WINDOW_DEFAULT_LO, 16'hBEEF, e_ok(shadow[10'h168]));
    req(FUNC_READ_HOLD, ADDR_WINDOW_DEFAULT_LO, 16'h0000, e_ok(shadow[10'h168]));
    req(8'h05, ADDR_WINDOW_FIRST_LO, 16'h0000, e_exc(EXC_ILLEGAL_FUNC));
    for (int i = 0; i < 4; i++) begin
      req(FUNC_READ_HOLD, bad[i], 16'h0000, e_exc(EXC_ILLEGAL_ADDR));
    end
    // Whole window with random pointers and data; the store delay is the last one drawn in the pointer loop
    // A pointer write answers with the pointer that it replaces
    for (int i = 0; i < 80; i++) begin
      lfsr = lfsr_next(lfsr);
      w = {7'h01, lfsr[8:0]};
      dly = {7'h00, lfsr[20:18]};
      req(FUNC_WRITE_MULTI, DEF_BASE_ADDR + 16'(i), w, e_ok(ptr[i]));
      ptr[i] = w;
    end
    for (int i = 0; i < 80; i++) begin
      lfsr = lfsr_next(lfsr);
      w = lfsr[31:16];
      req(FUNC_WRITE_MULTI, WORK_BASE_ADDR + 16'(i), w, e_ok(w));
      shadow[ptr[i][9:0]] = w;
    end
    for (int i = 0; i < 80; i++) begin
      req(FUNC_READ_HOLD, WORK_BASE_ADDR + 16'(i), 16'h0000, e_ok(shadow[ptr[i][9:0]]));
    end
    req(FUNC_WRITE_SINGLE, WORK_BASE_ADDR, 16'hA5A5, e_exc(EXC_ILLEGAL_FUNC));
    req(FUNC_READ_HOLD, WORK_BASE_ADDR, 16'h0000, e_ok(shadow[ptr[0][9:0]]));
    drain();
    // Store that never answers in time
    dly = 10'h12C;
    req(FUNC_READ_HOLD, WORK_BASE_ADDR, 16'h0000, e_exc(EXC_DEVICE_FAIL));
    drain();
    dly = 10'h000;
    // Second reset restores the default map and clears the rest
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    req(FUNC_READ_HOLD, ADDR_POINTER_EXAMPLE_LO, 16'h0000, e_ok(PTR_RESET_VAL));
    req(FUNC_READ_HOLD, 16'h0051, 16'h0000, e_ok(PTR_DEFAULT_HI));
    drain();
    end_of_test();
  end
endmodule : indirect_modbus_assembly_block_tb
